// ===== pkg/acr_pkg.sv
/*
  Shared constants, types and helpers for the converter selection and
  control block: I/O offsets, bit positions, reset values, codes and timing.
  Assumes an 8-bit CPU I/O bus with 6-bit I/O offsets.
*/
package acr_pkg;

  // I/O offsets of the block's registers; data-space address adds the offset below
  localparam logic [5:0] OFS_RES_LO = 6'h04;
  localparam logic [5:0] OFS_RES_HI = 6'h05;
  localparam logic [5:0] OFS_CTRL = 6'h06;
  localparam logic [5:0] OFS_SEL = 6'h07;
  localparam logic [7:0] DATA_SPACE_OFS = 8'h20;

  // Control and status bit positions
  localparam int CTRL_EN = 7;
  localparam int CTRL_START = 6;
  localparam int CTRL_FREE = 5;
  localparam int CTRL_FLAG = 4;
  localparam int CTRL_IE = 3;
  localparam int CTRL_PS_HI = 2;

  // Selection register fields
  localparam int SEL_REF_HI = 7;
  localparam int SEL_REF_LO = 6;
  localparam int SEL_JUST = 5;
  localparam int SEL_CHAN_HI = 4;

  // Reset values
  localparam logic [7:0] SEL_RST = 8'h00;
  localparam logic [7:0] CTRL_RST = 8'h00;

  // Reference codes
  localparam logic [1:0] REF_EXT = 2'h0;
  localparam logic [1:0] REF_AVCC = 2'h1;
  localparam logic [1:0] REF_RSVD = 2'h2;
  localparam logic [1:0] REF_INT = 2'h3;

  // Converter clocks per conversion
  localparam logic [4:0] CYC_FIRST = 5'h19;
  localparam logic [4:0] CYC_NORMAL = 5'h0d;

  typedef enum logic [1:0] {GAIN_1X, GAIN_10X, GAIN_200X} acr_gain_e;

  // Analog path steering towards the multiplexer and gain stage
  typedef struct packed {
    logic diff;
    logic bandgap;
    logic ground;
    logic [2:0] pos;
    logic [2:0] neg;
    acr_gain_e gain;
  } acr_path_s;

  // CPU I/O bus request
  typedef struct packed {
    logic [5:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } acr_io_req_s;

  // Prescaler select to division factor
  function automatic logic [7:0] acr_div(input logic [2:0] ps);
    acr_div = (ps == 3'h0) ? 8'h02 : (8'h01 << ps);
  endfunction

  // One result byte as seen through the justification setting
  function automatic logic [7:0] acr_byte(input logic [9:0] res, input logic left, input logic hi);
    if (left) begin
      acr_byte = hi ? res[9:2] : {res[1:0], 6'h00};
    end else begin
      acr_byte = hi ? {6'h00, res[9:8]} : res[7:0];
    end
  endfunction

endpackage

// ===== src/acr_chan_decode.sv
/*
  Channel code decoder: turns the five-bit channel code into the analog
  path steering (inputs, differential mode, gain, internal sources).
  Purely combinational; the caller registers the result.
*/
`timescale 1ns/1ps
module acr_chan_decode import acr_pkg::*; (
  input wire logic [4:0] chan,
  output acr_path_s path
);

  // Code table decode
  always_comb begin
    path = '0;
    path.gain = GAIN_1X;
    unique case (chan[4:3])
      2'h0: begin
        path.pos = chan[2:0];
      end
      2'h1: begin
        // Neg input 0 or 2, pos alternates; 01000/01010 short both terminals
        path.diff = 1'b1;
        path.neg = chan[2] ? 3'h2 : 3'h0;
        path.pos = path.neg + {2'h0, chan[0]};
        path.gain = chan[1] ? GAIN_200X : GAIN_10X;
      end
      2'h2: begin
        path.diff = 1'b1;
        path.pos = chan[2:0];
        path.neg = 3'h1;
      end
      2'h3: begin
        if (chan[2:1] == 2'h3) begin
          path.bandgap = ~chan[0];
          path.ground = chan[0];
        end else begin
          path.diff = 1'b1;
          path.pos = chan[2:0];
          path.neg = 3'h2;
        end
      end
    endcase
  end

endmodule // acr_chan_decode

// ===== src/acr_conv_ctrl.sv
/*
  Converter selection and control registers on the CPU I/O bus, with
  conversion sequencing, result byte mapping and read locking.
  Assumes a single-cycle I/O bus on sys_clk and a converter core whose
  result bus is sampled through two flip-flops.
*/
// What this block does
// - Reference field picks external, supply or internal
// - Selection writes deferred until conversion completes
// - Justify bit one gives left-adjusted result
// - Justify change remaps result bytes immediately
// - Codes 0-7 select single-ended inputs
// - Codes 8-15 differential, gain 10x/200x
// - Codes 16-29 differential pairs at unity gain
// - Codes 30/31 route bandgap or ground
// - Same-input codes usable for offset calibration
// - Enable bit powers converter up or down
// - Clearing enable aborts conversion, no result
// - Selection at 0x07, control at 0x06
// - Selection register resets to zero
// - Control register resets to zero
// - Result byte layout per justification
// - Low byte read locks result until high
// - Start bit runs conversion, 25 or 13 clocks
// - Done flag sets on completion, clears by ack/write-one
`timescale 1ns/1ps
module acr_conv_ctrl import acr_pkg::*; (
  input wire logic sys_clk,
  input wire logic rst,
  input acr_io_req_s io_req,
  output logic [7:0] io_rdata_q,
  input wire logic [9:0] core_data,
  input wire logic irq_ack,
  output acr_path_s path_q,
  output logic [1:0] ref_act_q,
  output logic conv_power_q,
  output logic conv_active_q,
  output logic irq_req_q
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations and bus decode

  logic [7:0] sel_q;
  logic en_q, busy_q, free_q, flag_q, ie_q, first_q, lock_q;
  logic [2:0] ps_q;
  logic [6:0] presc_q;
  logic [4:0] cyc_q;
  logic [9:0] result_q;
  logic [9:0] core_meta_q, core_sync_q;
  logic [4:0] chan_act_q;
  logic [11:0] conv_len_q;
  acr_path_s path_dec;
  logic wr_ctrl, wr_sel, rd_lo, rd_hi, start_req, abort, tick, done, apply;
  logic [7:0] div;
  logic [4:0] len;

  assign wr_ctrl = io_req.wr && (io_req.addr == OFS_CTRL);
  assign wr_sel = io_req.wr && (io_req.addr == OFS_SEL);
  assign rd_lo = io_req.rd && (io_req.addr == OFS_RES_LO);
  assign rd_hi = io_req.rd && (io_req.addr == OFS_RES_HI);
  // Start counts only when written together with the enable bit
  assign start_req = wr_ctrl && io_req.wdata[CTRL_START] && io_req.wdata[CTRL_EN] && !busy_q;
  assign abort = wr_ctrl && !io_req.wdata[CTRL_EN] && busy_q;
  assign div = acr_div(ps_q);
  assign len = first_q ? CYC_FIRST : CYC_NORMAL;
  assign tick = busy_q && (presc_q == 7'(div - 8'h01));
  assign done = tick && (cyc_q == len - 5'h01) && !abort;
  // Idle: selection follows the register; busy: only at completion
  assign apply = !busy_q || done;

  ////////////////////////////////////////////////////////////////////////////
  // Registers written by software

  // Selection register holds any code, reserved ones included
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sel_q <= SEL_RST;
    end else if (wr_sel) begin
      sel_q <= io_req.wdata;
    end
  end

  // Control fields; flag and start handled separately
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      en_q <= CTRL_RST[CTRL_EN];
      free_q <= CTRL_RST[CTRL_FREE];
      ie_q <= CTRL_RST[CTRL_IE];
      ps_q <= CTRL_RST[CTRL_PS_HI:0];
    end else if (wr_ctrl) begin
      en_q <= io_req.wdata[CTRL_EN];
      free_q <= io_req.wdata[CTRL_FREE];
      ie_q <= io_req.wdata[CTRL_IE];
      ps_q <= io_req.wdata[CTRL_PS_HI:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Conversion sequencing

  // Busy; free running restarts at completion without dropping busy
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      busy_q <= 1'b0;
    end else if (abort) begin
      busy_q <= 1'b0;
    end else if (start_req) begin
      busy_q <= 1'b1;
    end else if (done) begin
      busy_q <= free_q && en_q;
    end
  end

  // First conversion after enabling takes the longer initialisation run
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      first_q <= 1'b0;
    end else if (wr_ctrl && io_req.wdata[CTRL_EN] && !en_q) begin
      first_q <= 1'b1;
    end else if (done) begin
      first_q <= 1'b0;
    end
  end

  // Prescaler and converter clock count, cleared on every start
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      presc_q <= 7'h00;
      cyc_q <= 5'h00;
    end else if (!busy_q || start_req || done) begin
      presc_q <= 7'h00;
      cyc_q <= 5'h00;
    end else if (tick) begin
      presc_q <= 7'h00;
      cyc_q <= cyc_q + 5'h01;
    end else begin
      presc_q <= presc_q + 7'h01;
    end
  end

  // Analog result bus passes two flops before use
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      core_meta_q <= 10'h000;
      core_sync_q <= 10'h000;
    end else begin
      core_meta_q <= core_data;
      core_sync_q <= core_meta_q;
    end
  end

  // Result update is skipped while the low byte has been read but not the high
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      result_q <= 10'h000;
    end else if (done && !lock_q) begin
      result_q <= core_sync_q;
    end
  end

  // Read lock: low read sets, high read releases
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      lock_q <= 1'b0;
    end else if (rd_hi) begin
      lock_q <= 1'b0;
    end else if (rd_lo) begin
      lock_q <= 1'b1;
    end
  end

  // Done flag: setting wins over write-one and vector acknowledge
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      flag_q <= CTRL_RST[CTRL_FLAG];
    end else if (done) begin
      flag_q <= 1'b1;
    end else if ((wr_ctrl && io_req.wdata[CTRL_FLAG]) || irq_ack) begin
      flag_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Analog path steering

  acr_chan_decode u_dec (
    .chan(sel_q[SEL_CHAN_HI:0]),
    .path(path_dec)
  );

  // Active selection only moves when no conversion is mid-way
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ref_act_q <= REF_EXT;
      chan_act_q <= 5'h00;
      path_q <= '0;
    end else if (apply) begin
      ref_act_q <= sel_q[SEL_REF_HI:SEL_REF_LO];
      chan_act_q <= sel_q[SEL_CHAN_HI:0];
      path_q <= path_dec;
    end
  end

  // Status outputs towards core and interrupt logic
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      conv_power_q <= 1'b0;
      conv_active_q <= 1'b0;
      irq_req_q <= 1'b0;
    end else begin
      conv_power_q <= en_q;
      conv_active_q <= busy_q;
      irq_req_q <= flag_q && ie_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data; justification applied at read time so it takes effect at once

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      io_rdata_q <= 8'h00;
    end else if (io_req.rd) begin
      unique case (io_req.addr)
        OFS_RES_LO: io_rdata_q <= acr_byte(result_q, sel_q[SEL_JUST], 1'b0);
        OFS_RES_HI: io_rdata_q <= acr_byte(result_q, sel_q[SEL_JUST], 1'b1);
        OFS_CTRL: io_rdata_q <= {en_q, busy_q, free_q, flag_q, ie_q, ps_q};
        OFS_SEL: io_rdata_q <= sel_q;
        default: io_rdata_q <= 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  // Sys clock count of the running conversion
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      conv_len_q <= 12'h000;
    end else if (!busy_q || start_req || done) begin
      conv_len_q <= 12'h000;
    end else begin
      conv_len_q <= conv_len_q + 12'h001;
    end
  end

  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);

  AST_REF_DEFER: assert property (busy_q && !done |=> $stable(ref_act_q) && $stable(chan_act_q))
    else $error("selection changed mid conversion");
  AST_SEL_LATCH: assert property (done |=> chan_act_q == $past(sel_q[SEL_CHAN_HI:0]) && flag_q)
    else $error("selection not applied with flag");
  AST_FLAG_SET: assert property (done |=> flag_q ##1 irq_req_q == $past(ie_q))
    else $error("done flag not set");
  AST_ABORT: assert property (abort |=> !busy_q && $stable(result_q) ##1 !conv_power_q)
    else $error("abort did not stop conversion");
  AST_LENGTH: assert property (done |-> conv_len_q == 12'(len) * 12'(div) - 12'h001)
    else $error("conversion length wrong");
  AST_JUSTIFY: assert property (rd_hi && sel_q[SEL_JUST] |=> io_rdata_q == $past(result_q[9:2]))
    else $error("left high byte wrong");
  AST_RIGHT_HI: assert property (rd_hi && !sel_q[SEL_JUST] |=> io_rdata_q[7:2] == 6'h00)
    else $error("right high byte padding wrong");
  AST_LOCK: assert property (lock_q && !rd_hi |=> $stable(result_q))
    else $error("result changed while locked");
  AST_POWER: assert property (wr_ctrl && !io_req.wdata[CTRL_EN] |=> !busy_q ##1 !conv_power_q)
    else $error("converter not powered down");
  AST_START_RD: assert property (io_req.rd && io_req.addr == OFS_CTRL |=> io_rdata_q[6] == $past(busy_q))
    else $error("start bit does not show busy");

  // Idle selection follows the register one clock later
  AST_IDLE_FOLLOW: assert property (!busy_q |=> ref_act_q == $past(sel_q[SEL_REF_HI:SEL_REF_LO]))
    else $error("idle reference not applied");
  AST_SEL_STORE: assert property (wr_sel |=> sel_q == $past(io_req.wdata))
    else $error("selection write not stored");

  // Sequencing: start, long first run, free running, single shot and abort
  AST_START_GO: assert property (start_req |=> busy_q && conv_len_q == 12'h000)
    else $error("start did not begin a conversion");
  AST_FIRST_LEN: assert property (wr_ctrl && io_req.wdata[CTRL_EN] && !en_q |=> first_q)
    else $error("long first conversion not armed");
  AST_FREE_RUN: assert property (done && free_q && en_q |=> busy_q)
    else $error("free running did not restart");
  AST_SINGLE_END: assert property (done && !free_q |=> !busy_q)
    else $error("single conversion did not end");
  AST_ABORT_NOFLAG: assert property (abort && !flag_q |=> !flag_q)
    else $error("aborted conversion set the flag");

  // Flag clearing and result capture; a completion in the same cycle wins
  AST_WR_ONE_CLR: assert property (wr_ctrl && io_req.wdata[CTRL_FLAG] && !done |=> !flag_q)
    else $error("write one did not clear flag");
  AST_ACK_CLR: assert property (irq_ack && !done |=> !flag_q)
    else $error("vector acknowledge did not clear flag");
  AST_RESULT_UPD: assert property (done && !lock_q |=> result_q == $past(core_sync_q))
    else $error("result not captured at completion");
  AST_LOCK_SET: assert property (rd_lo |=> lock_q)
    else $error("low byte read did not lock result");

  // Low byte layout in both justifications
  AST_LEFT_LO: assert property (rd_lo && sel_q[SEL_JUST] |=> io_rdata_q == {$past(result_q[1:0]), 6'h00})
    else $error("left low byte wrong");
  AST_RIGHT_LO: assert property (rd_lo && !sel_q[SEL_JUST] |=> io_rdata_q == $past(result_q[7:0]))
    else $error("right low byte wrong");

endmodule // acr_conv_ctrl

// ===== dv/acr_core_model.sv
/*
  Behavioural converter core standing behind the selection and control block.
  Assumes conv_active follows the block's conversion-running output.
*/
`timescale 1ns/1ps
module acr_core_model (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic conv_active,
  input wire logic [9:0] sample,
  output logic [9:0] core_data
);
  logic held_q;
  ////////////////////////////////////////////////////////////////
  // Hold one sample while conv_active stays high; toggle when idle so stale data never looks valid
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      core_data <= 10'h155;
      held_q <= 1'b0;
    end else if (conv_active && !held_q) begin
      core_data <= sample;
      held_q <= 1'b1;
    end else if (!conv_active) begin
      core_data <= ~core_data;
      held_q <= 1'b0;
    end
  end
endmodule // acr_core_model

// ===== dv/tb_top.sv
/*
  Self-checking bench for the converter selection and control block.
  Assumes the package constants and a 40 MHz clock; prescaler 0 divides by 2.
*/
`timescale 1ns/1ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin num_errors++; \
  $display("wrong value %s expected %h seen %h", nm, e, g); end end
module tb_top import acr_pkg::*; ;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  acr_io_req_s io_req = '0;
  logic irq_ack = 1'b0;
  logic [7:0] io_rdata_q;
  logic [9:0] core_data;
  logic [9:0] sample = 10'h000;
  logic [9:0] last;
  acr_path_s path_q;
  logic [1:0] ref_act_q;
  logic conv_power_q, conv_active_q, irq_req_q;
  int num_errors = 0;
  int comparisons = 0;
  int seed = 81;
  int i;
  logic [7:0] d;
  logic [13:0] exp_q[$];
  logic [13:0] ent;
  logic rd_seen = 1'b0;

  always #12.5 sys_clk = ~sys_clk;

  acr_conv_ctrl u_acr_conv_ctrl (.sys_clk(sys_clk), .rst(rst), .io_req(io_req), .io_rdata_q(io_rdata_q),
    .core_data(core_data), .irq_ack(irq_ack), .path_q(path_q), .ref_act_q(ref_act_q),
    .conv_power_q(conv_power_q), .conv_active_q(conv_active_q), .irq_req_q(irq_req_q));
  acr_core_model u_acr_core_model (.sys_clk(sys_clk), .rst(rst), .conv_active(conv_active_q),
    .sample(sample), .core_data(core_data));

  ////////////////////////////////////////////////////////////////
  // Read checker: read data is settled by the falling edge after the taking edge
  always @(posedge sys_clk) rd_seen <= io_req.rd;
  always @(negedge sys_clk) begin
    if (rd_seen && exp_q.size() > 0) begin
      ent = exp_q.pop_front();
      `CHK("read data", ent[7:0], io_rdata_q)
    end
  end

  // Expected analog steering for a channel code
  function automatic acr_path_s exp_path(input logic [4:0] c);
    acr_path_s p;
    p = '0;
    if (c < 5'h08) begin
      p.pos = c[2:0];
    end else if (c < 5'h10) begin
      p.diff = 1'b1;
      p.neg = c[2] ? 3'h2 : 3'h0;
      p.pos = p.neg + {2'h0, c[0]};
      p.gain = c[1] ? GAIN_200X : GAIN_10X;
    end else if (c < 5'h1e) begin
      p.diff = 1'b1;
      p.pos = c[2:0];
      p.neg = c[3] ? 3'h2 : 3'h1;
    end else begin
      p.bandgap = !c[0];
      p.ground = c[0];
    end
    return p;
  endfunction

  // One bus cycle; strobes last exactly one clock
  task automatic io_cyc(input logic [5:0] a, input logic w, input logic [7:0] v);
    @(negedge sys_clk);
    io_req <= '{addr: a, wr: w, rd: !w, wdata: v};
    @(negedge sys_clk);
    io_req <= '0;
  endtask

  task automatic rd_chk(input logic [5:0] a, input logic [7:0] e);
    exp_q.push_back({a, e});
    io_cyc(a, 1'b0, 8'h00);
  endtask

  // Start and time a conversion by the span of the running output
  task automatic run_conv(input int cyc);
    int n;
    int w;
    n = 0;
    w = 0;
    io_cyc(OFS_CTRL, 1'b1, 8'hc0);
    while (!conv_active_q && w < 8) begin
      @(negedge sys_clk);
      w++;
    end
    while (conv_active_q && n < 4000) begin
      @(negedge sys_clk);
      n++;
    end
    `CHK("conversion length", cyc, n)
  endtask

  task automatic report_and_stop;
    `CHK("pending reads", 0, exp_q.size())
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////
  // Watchdog: the tests need well under a thousand clocks
  initial begin
    repeat (4000) @(posedge sys_clk);
    num_errors++;
    report_and_stop();
  end

  initial begin
    repeat (8) @(posedge sys_clk);
    @(negedge sys_clk) rst <= 1'b0;
    rd_chk(OFS_CTRL, CTRL_RST);
    rd_chk(OFS_SEL, SEL_RST);
    `CHK("active path", acr_path_s'('0), path_q)
    `CHK("irq request", 1'b0, irq_req_q)
    rd_chk(6'h10, 8'h00);
    $display("test reset done");
    // Every channel and reference code while idle
    for (i = 0; i < 32; i++) begin
      d = {i[1:0], 1'($random(seed)), i[4:0]};
      io_cyc(OFS_SEL, 1'b1, d);
      @(negedge sys_clk);
      `CHK("active path", exp_path(d[4:0]), path_q)
      `CHK("active reference", d[7:6], ref_act_q)
      rd_chk(OFS_SEL, d);
    end
    $display("test selection done");
    io_cyc(OFS_SEL, 1'b1, 8'h00);
    sample = 10'($random(seed));
    run_conv(50);
    last = sample;
    `CHK("power", 1'b1, conv_power_q)
    rd_chk(OFS_CTRL, 8'h90);
    rd_chk(OFS_RES_LO, last[7:0]);
    rd_chk(OFS_RES_HI, {6'h00, last[9:8]});
    io_cyc(OFS_SEL, 1'b1, 8'h20);
    rd_chk(OFS_RES_LO, {last[1:0], 6'h00});
    rd_chk(OFS_RES_HI, last[9:2]);
    $display("test first conversion done");
    io_cyc(OFS_CTRL, 1'b1, 8'h90);
    rd_chk(OFS_CTRL, 8'h80);
    sample = 10'($random(seed));
    fork
      run_conv(26);
      begin
        repeat (5) @(negedge sys_clk);
        io_cyc(OFS_SEL, 1'b1, 8'hed);
        rd_chk(OFS_CTRL, 8'hc0);
        `CHK("held path", exp_path(5'h00), path_q)
        `CHK("held reference", 2'h0, ref_act_q)
        rd_chk(OFS_RES_HI, last[9:2]);
        io_cyc(OFS_SEL, 1'b1, 8'hcd);
        rd_chk(OFS_RES_HI, {6'h00, last[9:8]});
      end
    join
    last = sample;
    `CHK("new path", exp_path(5'h0d), path_q)
    `CHK("new reference", 2'h3, ref_act_q)
    rd_chk(OFS_RES_LO, last[7:0]);
    rd_chk(OFS_RES_HI, {6'h00, last[9:8]});
    $display("test deferred selection done");
    rd_chk(OFS_RES_LO, last[7:0]);
    sample = last ^ 10'h300;
    run_conv(26);
    rd_chk(OFS_CTRL, 8'h90);
    rd_chk(OFS_RES_HI, {6'h00, last[9:8]});
    @(negedge sys_clk) irq_ack <= 1'b1;
    @(negedge sys_clk) irq_ack <= 1'b0;
    rd_chk(OFS_CTRL, 8'h80);
    $display("test read lock done");
    io_cyc(OFS_CTRL, 1'b1, 8'hc0);
    repeat (6) @(negedge sys_clk);
    io_cyc(OFS_CTRL, 1'b1, 8'h00);
    io_cyc(OFS_RES_HI, 1'b1, 8'hff);
    `CHK("running", 1'b0, conv_active_q)
    `CHK("power", 1'b0, conv_power_q)
    rd_chk(OFS_CTRL, 8'h00);
    rd_chk(OFS_RES_HI, {6'h00, last[9:8]});
    sample = 10'($random(seed));
    run_conv(50);
    rd_chk(OFS_RES_LO, sample[7:0]);
    rd_chk(OFS_RES_HI, {6'h00, sample[9:8]});
    $display("test abort done");
    // Free running at divide by four with the interrupt request enabled
    sample = 10'($random(seed));
    io_cyc(OFS_CTRL, 1'b1, 8'hfa);
    repeat (54) @(negedge sys_clk);
    `CHK("irq request", 1'b1, irq_req_q)
    `CHK("free running", 1'b1, conv_active_q)
    rd_chk(OFS_CTRL, 8'hfa);
    io_cyc(OFS_CTRL, 1'b1, 8'h9a);
    repeat (60) @(negedge sys_clk);
    `CHK("irq request", 1'b1, irq_req_q)
    `CHK("running", 1'b0, conv_active_q)
    rd_chk(OFS_CTRL, 8'h9a);
    rd_chk(OFS_RES_LO, sample[7:0]);
    rd_chk(OFS_RES_HI, {6'h00, sample[9:8]});
    @(negedge sys_clk) irq_ack <= 1'b1;
    @(negedge sys_clk) irq_ack <= 1'b0;
    @(negedge sys_clk);
    `CHK("irq request", 1'b0, irq_req_q)
    rd_chk(OFS_CTRL, 8'h8a);
    $display("test free running done");
    repeat (4) @(negedge sys_clk);
    report_and_stop();
  end
endmodule // tb_top
